// ===== verilog/lmac_core.sv
// mission setup, alarm decisions and data logging behind an axi4-lite slave
// Operation
// - temp enables and clock bits 7:2 read zero
// - humidity enable 7:2, setup 7:6 read one
// - config registers read-only during a mission
// - temp high enabled, msb at/above threshold flags
// - temp low enabled, msb at/below threshold flags
// - temp thresholds and alarm status at listed slots
// - humidity high enabled, at/above threshold flags
// - humidity low enabled, at/below threshold flags
// - humidity thresholds at listed slots
// - sample unit bit picks seconds or minutes
// - oscillator enable runs or stops timekeeping
// - forced conversion or start sets oscillator enable
// - start-on-alarm waits, logs the alarming reading
// - first alarm-triggered sample is not counted
// - start-on-alarm needs temperature logging enabled
// - wrap mode overwrites from log start
// - no wrap: stop logging when full
// - humidity format 8 or 16 bit, msb first
// - temperature format 8 or 16 bit, msb first
// - humidity log start depends on formats
// - temperature log always starts at 1000h
// - start needs temperature or humidity logging
// - alarms compare only the most significant byte
// - alarm status holds four flags, read-only
// - clear command clears flags outside a mission, otherwise sticky
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lmac_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // conversion results
  input wire logic conv_done,
  input wire logic [15:0] conv_temp,
  input wire logic [15:0] conv_humid,
  // control and status outputs
  output logic conv_request,
  output logic osc_run,
  output logic sample_unit_seconds,
  output logic mission_active,
  output logic temp_only_8bit,
  output logic log_full,
  output logic [3:0] alarm_flags
);
  typedef struct packed {
    logic [7:0] t_lo_th;
    logic [7:0] t_hi_th;
    logic [7:0] h_lo_th;
    logic [7:0] h_hi_th;
    logic [1:0] t_en;
    logic [1:0] h_en;
    logic [1:0] clk_run;
    logic [5:0] setup;
    logic [3:0] flags;
    logic active;
    logic waiting;
    logic full;
    logic do_h;
    logic conv_req;
    logic [23:0] samples;
    logic [13:0] t_ptr;
    logic [13:0] h_ptr;
    lmac_pkg::lmac_seq_t seq;
    logic [15:0] t_val;
    logic [15:0] h_val;
    logic aw_ok;
    logic [13:0] aw_idx;
    logic w_ok;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rpend;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
  } lmac_state_t;

  lmac_state_t s, n;

  // decoding helpers
  function automatic logic in_log(input logic [13:0] idx);
    in_log = (idx >= lmac_pkg::LOG_BASE) && (idx < lmac_pkg::LOG_TOP);
  endfunction : in_log

  function automatic logic known_idx(input logic [13:0] idx);
    known_idx = ((idx >= lmac_pkg::IDX_T_LO_TH) && (idx <= lmac_pkg::IDX_H_HI_TH))
      || ((idx >= lmac_pkg::IDX_TEMP_EN) && (idx <= lmac_pkg::IDX_GSTAT))
      || ((idx >= lmac_pkg::IDX_SAMP0) && (idx <= lmac_pkg::IDX_SAMP2))
      || (idx == lmac_pkg::IDX_CMD);
  endfunction : known_idx

  function automatic logic [13:0] hum_start(input logic [5:0] cfg);
    if (!cfg[lmac_pkg::SET_LOG_T]) begin
      hum_start = lmac_pkg::LOG_BASE;
    end else if (cfg[lmac_pkg::SET_T_WIDE] == cfg[lmac_pkg::SET_H_WIDE]) begin
      hum_start = lmac_pkg::H_START_SAME;
    end else if (!cfg[lmac_pkg::SET_T_WIDE]) begin
      hum_start = lmac_pkg::H_START_T8_H16;
    end else begin
      hum_start = lmac_pkg::H_START_T16_H8;
    end
  endfunction : hum_start

  logic do_wr, cmd_wr, start_ok, ar_hs;
  logic [13:0] ar_idx, t_end, t_need, h_need;
  logic [7:0] rd_byte, mem_rd, mem_wd;
  logic t_hi_hit, t_lo_hit, h_hi_hit, h_lo_hit;
  logic ev, trig, log_ev, want, need_h, fits, go;
  logic mem_we;
  logic [12:0] mem_wa, mem_ra;

  assign s_axi_awready = !s.aw_ok;
  assign s_axi_wready = !s.w_ok;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid && !s.rpend;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h000000, s.rbyte};
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[15:2];
  assign do_wr = s.aw_ok && s.w_ok && !s.bvalid;
  assign cmd_wr = do_wr && s.wlane && (s.aw_idx == lmac_pkg::IDX_CMD);
  assign start_ok = cmd_wr && s.wbyte[lmac_pkg::CMD_START] && !s.active
    && (s.setup[lmac_pkg::SET_LOG_T] || s.setup[lmac_pkg::SET_LOG_H]);

  assign conv_request = s.conv_req;
  assign osc_run = s.clk_run[lmac_pkg::CLK_OSC];
  assign sample_unit_seconds = s.clk_run[lmac_pkg::CLK_SECONDS];
  assign mission_active = s.active;
  assign temp_only_8bit = s.waiting;
  assign log_full = s.full;
  assign alarm_flags = s.flags;

  // alarm comparisons on the conversion msb
  assign t_hi_hit = conv_temp[15:8] >= s.t_hi_th;
  assign t_lo_hit = conv_temp[15:8] <= s.t_lo_th;
  assign h_hi_hit = conv_humid[15:8] >= s.h_hi_th;
  assign h_lo_hit = conv_humid[15:8] <= s.h_lo_th;

  // sample events and room in the log
  assign ev = conv_done && s.active && !s.full && (s.seq == lmac_pkg::SEQ_IDLE);
  assign trig = ev && s.waiting && (t_hi_hit || t_lo_hit);
  assign log_ev = ev && !s.waiting;
  assign want = trig || log_ev;
  assign need_h = log_ev && s.setup[lmac_pkg::SET_LOG_H];
  assign t_end = s.setup[lmac_pkg::SET_LOG_H] ? hum_start(s.setup) : lmac_pkg::LOG_TOP;
  assign t_need = s.setup[lmac_pkg::SET_T_WIDE] ? 14'h0002 : 14'h0001;
  assign h_need = s.setup[lmac_pkg::SET_H_WIDE] ? 14'h0002 : 14'h0001;
  assign fits = (!s.setup[lmac_pkg::SET_LOG_T] || (14'(s.t_ptr + t_need) <= t_end))
    && (!need_h || (14'(s.h_ptr + h_need) <= lmac_pkg::LOG_TOP));
  assign go = want && (fits || s.setup[lmac_pkg::SET_WRAP]);

  // register read mux
  always_comb begin
    rd_byte = 8'h00;
    if (ar_idx == lmac_pkg::IDX_T_LO_TH) begin
      rd_byte = s.t_lo_th;
    end else if (ar_idx == lmac_pkg::IDX_T_HI_TH) begin
      rd_byte = s.t_hi_th;
    end else if (ar_idx == lmac_pkg::IDX_H_LO_TH) begin
      rd_byte = s.h_lo_th;
    end else if (ar_idx == lmac_pkg::IDX_H_HI_TH) begin
      rd_byte = s.h_hi_th;
    end else if (ar_idx == lmac_pkg::IDX_TEMP_EN) begin
      rd_byte = {6'h00, s.t_en};
    end else if (ar_idx == lmac_pkg::IDX_HUM_EN) begin
      rd_byte = lmac_pkg::HUM_EN_FILL | {6'h00, s.h_en};
    end else if (ar_idx == lmac_pkg::IDX_CLK_RUN) begin
      rd_byte = {6'h00, s.clk_run};
    end else if (ar_idx == lmac_pkg::IDX_SETUP) begin
      rd_byte = lmac_pkg::SETUP_FILL | {2'b00, s.setup};
    end else if (ar_idx == lmac_pkg::IDX_ALARM) begin
      rd_byte = lmac_pkg::ALARM_FILL | {4'h0, s.flags};
    end else if (ar_idx == lmac_pkg::IDX_GSTAT) begin
      rd_byte = lmac_pkg::GSTAT_FILL | {3'b000, s.waiting, 2'b00, s.active, s.full};
    end else if (ar_idx == lmac_pkg::IDX_SAMP0) begin
      rd_byte = s.samples[7:0];
    end else if (ar_idx == lmac_pkg::IDX_SAMP1) begin
      rd_byte = s.samples[15:8];
    end else if (ar_idx == lmac_pkg::IDX_SAMP2) begin
      rd_byte = s.samples[23:16];
    end
  end

  // next state
  always_comb begin
    n = s;
    n.conv_req = 1'b0;
    mem_we = 1'b0;
    mem_wa = 13'h0000;
    mem_wd = 8'h00;
    mem_ra = 13'(14'(ar_idx - lmac_pkg::LOG_BASE));
    // write channels
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_ok = 1'b1;
      n.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_ok = 1'b1;
      n.wbyte = s_axi_wdata[7:0];
      n.wlane = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (do_wr) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = known_idx(s.aw_idx) ? lmac_pkg::RESP_OKAY : lmac_pkg::RESP_SLVERR;
      if (s.wlane && !s.active) begin
        if (s.aw_idx == lmac_pkg::IDX_T_LO_TH) begin
          n.t_lo_th = s.wbyte;
        end else if (s.aw_idx == lmac_pkg::IDX_T_HI_TH) begin
          n.t_hi_th = s.wbyte;
        end else if (s.aw_idx == lmac_pkg::IDX_H_LO_TH) begin
          n.h_lo_th = s.wbyte;
        end else if (s.aw_idx == lmac_pkg::IDX_H_HI_TH) begin
          n.h_hi_th = s.wbyte;
        end else if (s.aw_idx == lmac_pkg::IDX_TEMP_EN) begin
          n.t_en = s.wbyte[1:0];
        end else if (s.aw_idx == lmac_pkg::IDX_HUM_EN) begin
          n.h_en = s.wbyte[1:0];
        end else if (s.aw_idx == lmac_pkg::IDX_CLK_RUN) begin
          n.clk_run = s.wbyte[1:0];
        end else if (s.aw_idx == lmac_pkg::IDX_SETUP) begin
          n.setup = s.wbyte[5:0];
        end
      end
    end
    // commands
    if (cmd_wr) begin
      if (s.wbyte[lmac_pkg::CMD_FORCE]) begin
        n.clk_run[lmac_pkg::CLK_OSC] = 1'b1;
        n.conv_req = 1'b1;
      end
      if (start_ok) begin
        n.active = 1'b1;
        n.clk_run[lmac_pkg::CLK_OSC] = 1'b1;
        n.waiting = s.setup[lmac_pkg::SET_START_ON_TEMP_ALARM] && s.setup[lmac_pkg::SET_LOG_T];
        n.full = 1'b0;
        n.t_ptr = lmac_pkg::LOG_BASE;
        n.h_ptr = hum_start(s.setup);
      end
      if (s.wbyte[lmac_pkg::CMD_STOP] && s.active) begin
        n.active = 1'b0;
      end
      if (s.wbyte[lmac_pkg::CMD_CLEAR] && !s.active) begin
        n.flags = 4'h0;
        n.samples = 24'h000000;
      end
    end
    // alarm flags stay set once raised, until a clear command outside a mission
    if (ev && s.t_en[lmac_pkg::EN_HI] && t_hi_hit) begin
      n.flags[lmac_pkg::FLAG_TH] = 1'b1;
    end
    if (ev && s.t_en[lmac_pkg::EN_LO] && t_lo_hit) begin
      n.flags[lmac_pkg::FLAG_TL] = 1'b1;
    end
    if (log_ev && s.h_en[lmac_pkg::EN_HI] && h_hi_hit) begin
      n.flags[lmac_pkg::FLAG_HH] = 1'b1;
    end
    if (log_ev && s.h_en[lmac_pkg::EN_LO] && h_lo_hit) begin
      n.flags[lmac_pkg::FLAG_HL] = 1'b1;
    end
    // log full handling
    if (want && !fits) begin
      if (s.setup[lmac_pkg::SET_WRAP]) begin
        n.t_ptr = lmac_pkg::LOG_BASE;
        n.h_ptr = hum_start(s.setup);
      end else begin
        n.full = 1'b1;
      end
    end
    if (trig) begin
      n.waiting = 1'b0;
    end
    if (go) begin
      n.t_val = conv_temp;
      n.h_val = conv_humid;
      n.do_h = need_h;
      n.seq = s.setup[lmac_pkg::SET_LOG_T] ? lmac_pkg::SEQ_TH : lmac_pkg::SEQ_HH;
      if (!trig) begin
        n.samples = 24'(s.samples + 24'h000001);
      end
    end
    // log byte sequencer, msb at the lower address
    case (s.seq)
      lmac_pkg::SEQ_TH: begin
        mem_we = 1'b1;
        mem_wa = 13'(14'(s.t_ptr - lmac_pkg::LOG_BASE));
        mem_wd = s.t_val[15:8];
        n.t_ptr = 14'(s.t_ptr + 14'h0001);
        if (s.setup[lmac_pkg::SET_T_WIDE]) begin
          n.seq = lmac_pkg::SEQ_TL;
        end else begin
          n.seq = s.do_h ? lmac_pkg::SEQ_HH : lmac_pkg::SEQ_IDLE;
        end
      end
      lmac_pkg::SEQ_TL: begin
        mem_we = 1'b1;
        mem_wa = 13'(14'(s.t_ptr - lmac_pkg::LOG_BASE));
        mem_wd = s.t_val[7:0];
        n.t_ptr = 14'(s.t_ptr + 14'h0001);
        n.seq = s.do_h ? lmac_pkg::SEQ_HH : lmac_pkg::SEQ_IDLE;
      end
      lmac_pkg::SEQ_HH: begin
        mem_we = 1'b1;
        mem_wa = 13'(14'(s.h_ptr - lmac_pkg::LOG_BASE));
        mem_wd = s.h_val[15:8];
        n.h_ptr = 14'(s.h_ptr + 14'h0001);
        n.seq = s.setup[lmac_pkg::SET_H_WIDE] ? lmac_pkg::SEQ_HL : lmac_pkg::SEQ_IDLE;
      end
      lmac_pkg::SEQ_HL: begin
        mem_we = 1'b1;
        mem_wa = 13'(14'(s.h_ptr - lmac_pkg::LOG_BASE));
        mem_wd = s.h_val[7:0];
        n.h_ptr = 14'(s.h_ptr + 14'h0001);
        n.seq = lmac_pkg::SEQ_IDLE;
      end
      default: begin
        n.seq = go ? n.seq : lmac_pkg::SEQ_IDLE;
      end
    endcase
    // read channels
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.rpend) begin
      n.rpend = 1'b0;
      n.rvalid = 1'b1;
      n.rbyte = mem_rd;
    end
    if (ar_hs) begin
      if (in_log(ar_idx)) begin
        n.rpend = 1'b1;
        n.rresp = lmac_pkg::RESP_OKAY;
      end else begin
        n.rvalid = 1'b1;
        n.rbyte = rd_byte;
        n.rresp = known_idx(ar_idx) ? lmac_pkg::RESP_OKAY : lmac_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.seq <= lmac_pkg::SEQ_IDLE;
      s.t_ptr <= lmac_pkg::LOG_BASE;
      s.h_ptr <= lmac_pkg::LOG_BASE;
    end else begin
      s <= n;
    end
  end

  lmac_log_mem u_log_mem (
    .clk(clk),
    .we(mem_we),
    .wa(mem_wa),
    .wd(mem_wd),
    .ra(mem_ra),
    .rd_q(mem_rd)
  );

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  temp_en_zero_a: assert property (ar_hs && ar_idx == lmac_pkg::IDX_TEMP_EN
    |=> s_axi_rvalid && s_axi_rdata[7:2] == 6'h00) else $error("temp enable high bits set");
  hum_en_ones_a: assert property (ar_hs && ar_idx == lmac_pkg::IDX_HUM_EN
    |=> s_axi_rvalid && s_axi_rdata[7:2] == 6'h3F) else $error("humid enable fill wrong");
  setup_lock_a: assert property (do_wr && s.active
    |=> $stable(s.setup) && $stable(s.t_en)) else $error("config changed in mission");
  temp_high_a: assert property (ev && s.t_en[1] && t_hi_hit |=> alarm_flags[1])
    else $error("temp high flag missed");
  temp_low_a: assert property (ev && s.t_en[0] && t_lo_hit |=> alarm_flags[0])
    else $error("temp low flag missed");
  humid_high_a: assert property (log_ev && s.h_en[1] && h_hi_hit |=> alarm_flags[3])
    else $error("humid high flag missed");
  humid_low_a: assert property (log_ev && s.h_en[0] && h_lo_hit |=> alarm_flags[2])
    else $error("humid low flag missed");
  osc_start_a: assert property (cmd_wr && s.wbyte[2] |=> osc_run && conv_request)
    else $error("forced conversion left oscillator off");
  first_count_a: assert property (trig |=> $stable(s.samples))
    else $error("alarm trigger counted a sample");
  hum_base_a: assert property (start_ok |=> s.h_ptr == hum_start(s.setup))
    else $error("humidity log start wrong");
  full_hold_a: assert property (s.full && s.active && !cmd_wr
    |=> log_full && mission_active) else $error("full mission ended early");
  wide_order_a: assert property (s.seq == lmac_pkg::SEQ_TH && s.setup[2]
    |-> mem_wd == s.t_val[15:8] ##1 mem_wa == 13'($past(mem_wa) + 13'h0001))
    else $error("wide temperature bytes out of order");
  flag_clear_a: assert property (cmd_wr && s.wbyte[3] && !s.active
    |=> alarm_flags == 4'h0) else $error("clear left alarm flags");

  start_c: cover property (start_ok);
  trigger_c: cover property (trig);
  wrap_c: cover property (want && !fits && s.setup[4]);
  full_c: cover property ($rose(log_full));
endmodule : lmac_core
`default_nettype wire

// ===== verilog/lmac_pkg.sv
// constants and types shared by the mission and alarm control block
package lmac_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_T_LO_TH = 14'h0208;
  localparam logic [13:0] IDX_T_HI_TH = 14'h0209;
  localparam logic [13:0] IDX_H_LO_TH = 14'h020A;
  localparam logic [13:0] IDX_H_HI_TH = 14'h020B;
  localparam logic [13:0] IDX_TEMP_EN = 14'h0210;
  localparam logic [13:0] IDX_HUM_EN = 14'h0211;
  localparam logic [13:0] IDX_CLK_RUN = 14'h0212;
  localparam logic [13:0] IDX_SETUP = 14'h0213;
  localparam logic [13:0] IDX_ALARM = 14'h0214;
  localparam logic [13:0] IDX_GSTAT = 14'h0215;
  localparam logic [13:0] IDX_SAMP0 = 14'h0220;
  localparam logic [13:0] IDX_SAMP1 = 14'h0221;
  localparam logic [13:0] IDX_SAMP2 = 14'h0222;
  localparam logic [13:0] IDX_CMD = 14'h0230;
  // data-log memory window
  localparam logic [13:0] LOG_BASE = 14'h1000;
  localparam logic [13:0] LOG_TOP = 14'h3000;
  localparam logic [13:0] H_START_SAME = 14'h2000;
  localparam logic [13:0] H_START_T8_H16 = 14'h1A00;
  localparam logic [13:0] H_START_T16_H8 = 14'h2400;
  localparam int LOG_DEPTH = 8192;
  localparam int LOG_AW = 13;
  // fixed bits of read-back values
  localparam logic [7:0] HUM_EN_FILL = 8'hFC;
  localparam logic [7:0] SETUP_FILL = 8'hC0;
  localparam logic [7:0] ALARM_FILL = 8'h70;
  localparam logic [7:0] GSTAT_FILL = 8'hC0;
  // enable register fields
  localparam int EN_LO = 0;
  localparam int EN_HI = 1;
  // clock run fields
  localparam int CLK_OSC = 0;
  localparam int CLK_SECONDS = 1;
  // mission setup fields
  localparam int SET_LOG_T = 0;
  localparam int SET_LOG_H = 1;
  localparam int SET_T_WIDE = 2;
  localparam int SET_H_WIDE = 3;
  localparam int SET_WRAP = 4;
  localparam int SET_START_ON_TEMP_ALARM = 5;
  // alarm flag positions
  localparam int FLAG_TL = 0;
  localparam int FLAG_TH = 1;
  localparam int FLAG_HL = 2;
  localparam int FLAG_HH = 3;
  // command register bits
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_FORCE = 2;
  localparam int CMD_CLEAR = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // log byte sequencer
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'b00001,
    SEQ_TH = 5'b00010,
    SEQ_TL = 5'b00100,
    SEQ_HH = 5'b01000,
    SEQ_HL = 5'b10000
  } lmac_seq_t;
endpackage : lmac_pkg

// ===== verilog/lmac_log_mem.sv
// data-log byte memory, one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none
module lmac_log_mem (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [12:0] wa,
  input wire logic [7:0] wd,
  // read port
  input wire logic [12:0] ra,
  output logic [7:0] rd_q
);
  logic [7:0] mem [lmac_pkg::LOG_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd_q <= mem[ra];
  end
endmodule : lmac_log_mem
`default_nettype wire

// ===== tb/lmac_sensor_model.sv
// sensor side model that hands conversion results to the block
`timescale 1ns/10ps
`default_nettype none
module lmac_sensor_model (
  // clock
  input wire logic clk,
  // requests from bench and block
  input wire logic fire,
  input wire logic conv_request,
  input wire logic [15:0] temp_in,
  input wire logic [15:0] humid_in,
  // conversion results
  output logic conv_done,
  output logic [15:0] conv_temp,
  output logic [15:0] conv_humid
);
  logic req_q;
  initial begin
    req_q = 0;
    conv_done = 0;
    conv_temp = 16'h0000;
    conv_humid = 16'h0000;
  end
  // result lines flip on every edge where fire is low, even when a requested conversion is offered
  always @(posedge clk) begin
    req_q <= conv_request;
    conv_done <= fire | req_q;
    conv_temp <= fire ? temp_in : ~conv_temp;
    conv_humid <= fire ? humid_in : ~conv_humid;
  end
endmodule : lmac_sensor_model
`default_nettype wire

// ===== tb/logger_mission_alarm_control_tb_top.sv
// bench for the mission and alarm control block
`timescale 1ns/10ps
`default_nettype none
module logger_mission_alarm_control_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic [15:0] awaddr = 0, araddr = 0, ft = 0, fh = 0, ct, ch;
  logic awvalid = 0, wvalid = 0, arvalid = 0, fire = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, done, creq, osc, sus, act, t8, full;
  logic [3:0] flags, ef = 0;
  logic [7:0] lf = 8'h1A, rd, t, h, c;
  logic [7:0] tq[$], hq[$];
  int failures = 0, checks = 0, n;
  always #10 clk = ~clk;
  lmac_core dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .conv_done(done),
    .conv_temp(ct), .conv_humid(ch), .conv_request(creq), .osc_run(osc),
    .sample_unit_seconds(sus), .mission_active(act), .temp_only_8bit(t8),
    .log_full(full), .alarm_flags(flags));
  lmac_sensor_model sm (.clk(clk), .fire(fire), .conv_request(creq), .temp_in(ft),
    .humid_in(fh), .conv_done(done), .conv_temp(ct), .conv_humid(ch));
  function automatic logic [7:0] lfsr();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : lfsr
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // one write, then one edge so outputs settle
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    logic a, w;
    a = 1;
    w = 1;
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    while (a || w) begin
      @(posedge clk);
      if (awready === 1'b1) a = 0;
      if (wready === 1'b1) w = 0;
      awvalid <= a;
      wvalid <= w;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk);
  endtask : wr
  task automatic rdr(input logic [13:0] i, output logic [7:0] d);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    rs = rresp;
  endtask : rdr
  task automatic rc(input logic [13:0] i, input logic [7:0] e);
    rdr(i, rd);
    chk(rd, e);
  endtask : rc
  task automatic conv(input logic [7:0] tv, input logic [7:0] hv);
    ft <= {tv, lfsr()};
    fh <= {hv, lfsr()};
    fire <= 1;
    @(posedge clk);
    fire <= 0;
    repeat (8) @(posedge clk);
  endtask : conv
  initial begin
    #1000000;
    failures++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(lmac_pkg::IDX_TEMP_EN, 8'h00);
    rc(lmac_pkg::IDX_HUM_EN, 8'hFC);
    rc(lmac_pkg::IDX_CLK_RUN, 8'h00);
    rc(lmac_pkg::IDX_SETUP, 8'hC0);
    wr(lmac_pkg::IDX_ALARM, 8'h0F);
    rc(lmac_pkg::IDX_ALARM, 8'h70);
    wr(lmac_pkg::IDX_TEMP_EN, 8'hFE);
    rc(lmac_pkg::IDX_TEMP_EN, 8'h02);
    wr(lmac_pkg::IDX_HUM_EN, 8'h03);
    rc(lmac_pkg::IDX_HUM_EN, 8'hFF);
    wr(lmac_pkg::IDX_CLK_RUN, 8'hFE);
    rc(lmac_pkg::IDX_CLK_RUN, 8'h02);
    chk({6'h00, osc, sus}, 8'h01);
    wr(lmac_pkg::IDX_SETUP, 8'h03);
    rc(lmac_pkg::IDX_SETUP, 8'hC3);
    wr(lmac_pkg::IDX_T_LO_TH, 8'h40);
    wr(lmac_pkg::IDX_T_HI_TH, 8'hC0);
    wr(lmac_pkg::IDX_H_LO_TH, 8'h50);
    wr(lmac_pkg::IDX_H_HI_TH, 8'hB0);
    rc(lmac_pkg::IDX_T_LO_TH, 8'h40);
    rc(lmac_pkg::IDX_T_HI_TH, 8'hC0);
    rc(lmac_pkg::IDX_H_LO_TH, 8'h50);
    rc(lmac_pkg::IDX_H_HI_TH, 8'hB0);
    rc(14'h0100, 8'h00);
    chk({6'h00, rs}, {6'h00, lmac_pkg::RESP_SLVERR});
    wr(lmac_pkg::LOG_BASE, 8'h00);
    chk({6'h00, rs}, {6'h00, lmac_pkg::RESP_SLVERR});
    $display("test registers done");
    wr(lmac_pkg::IDX_CMD, 8'h01);
    chk({6'h00, osc, act}, 8'h03);
    wr(lmac_pkg::IDX_T_LO_TH, 8'h11);
    rc(lmac_pkg::IDX_T_LO_TH, 8'h40);
    wr(lmac_pkg::IDX_TEMP_EN, 8'h00);
    rc(lmac_pkg::IDX_TEMP_EN, 8'h02);
    // temp low disabled, the rest enabled
    for (n = 0; n < 8; n++) begin
      t = n == 0 ? 8'hBF : n == 1 ? 8'hC0 : lfsr();
      h = n == 0 ? 8'h51 : n == 1 ? 8'h50 : lfsr();
      ef = ef | {h >= 8'hB0, h <= 8'h50, t >= 8'hC0, 1'b0};
      tq.push_back(t);
      hq.push_back(h);
      conv(t, h);
      chk({4'h0, flags}, {4'h0, ef});
    end
    for (n = 0; n < 8; n++) begin
      rc(lmac_pkg::LOG_BASE + 14'(n), tq[n]);
      rc(lmac_pkg::H_START_SAME + 14'(n), hq[n]);
    end
    rc(lmac_pkg::IDX_SAMP0, 8'h08);
    wr(lmac_pkg::IDX_CMD, 8'h02);
    chk({7'h00, act}, 8'h00);
    rc(lmac_pkg::IDX_ALARM, {4'h7, ef});
    wr(lmac_pkg::IDX_CLK_RUN, 8'h00);
    chk({7'h00, osc}, 8'h00);
    wr(lmac_pkg::IDX_CMD, 8'h04);
    repeat (6) @(posedge clk);
    chk({3'h0, osc, flags}, {4'h1, ef});
    $display("test mission done");
    wr(lmac_pkg::IDX_CMD, 8'h08);
    chk({4'h0, flags}, 8'h00);
    wr(lmac_pkg::IDX_TEMP_EN, 8'h03);
    wr(lmac_pkg::IDX_SETUP, 8'h21);
    wr(lmac_pkg::IDX_CMD, 8'h01);
    chk({7'h00, t8}, 8'h01);
    rdr(lmac_pkg::IDX_SAMP0, c);
    conv(8'h80, 8'h80);
    chk({3'h0, t8, flags}, 8'h10);
    conv(8'h20, 8'h80);
    chk({3'h0, t8, flags}, 8'h01);
    rc(lmac_pkg::IDX_SAMP0, c);
    rc(lmac_pkg::LOG_BASE, 8'h20);
    conv(8'h80, 8'h80);
    rc(lmac_pkg::IDX_SAMP0, c + 8'h01);
    $display("test alarm start done");
    wr(lmac_pkg::IDX_CMD, 8'h02);
    wr(lmac_pkg::IDX_CMD, 8'h08);
    wr(lmac_pkg::IDX_SETUP, 8'h0F);
    rc(lmac_pkg::IDX_SETUP, 8'hCF);
    wr(lmac_pkg::IDX_CMD, 8'h01);
    conv(8'h81, 8'h82);
    rc(lmac_pkg::LOG_BASE, 8'h81);
    rc(lmac_pkg::LOG_BASE + 14'h0001, ft[7:0]);
    rc(lmac_pkg::H_START_SAME, 8'h82);
    rc(lmac_pkg::H_START_SAME + 14'h0001, fh[7:0]);
    for (n = 1; n < 2048; n++) begin
      conv(8'h80, 8'h80);
    end
    chk({6'h00, full, act}, 8'h01);
    conv(8'h80, 8'h80);
    chk({6'h00, full, act}, 8'h03);
    rc(lmac_pkg::IDX_SAMP0, 8'h00);
    rc(lmac_pkg::IDX_SAMP1, 8'h08);
    $display("test full log done");
    final_report();
  end
endmodule : logger_mission_alarm_control_tb_top
`default_nettype wire
